// *** core/spi_conv_dev.sv ***
// spi_conv_dev: converter end of the serial link, protocol select, read framing, chain and lanes
// assumes link pins are asynchronous to clk_sys and each level lasts well over three clocks
// Notes on behaviour
// - result high half, then chain, alarm, range, parity
// - writes accepted in all four clock modes
// - mode 0..3 map polarity and capture edge
// - reset selects idle-low rising-capture mode
// - host changes mode using current mode
// - selected mode governs reads and writes
// - writes need at least 32 clocks
// - first bit launch depends on mode
// - host sets read select zero for SPI
// - read select picks source-synchronous reads
// - strobe low throughout SPI read frames
// - short frames read leading bits only
// - long frames shift input bits onward while output control is zero
// - lane config 11b makes shared pin lane
// - dual lane launches two bits per edge
// - dual lane needs half the clocks
// - source-synchronous mode forwards clock on strobe
// - forwarded clock from host clock or internal
// - dual lane halves forwarded clock cycles
// - command acts at select rising edge
// - host commands are exactly 32 bits
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`include "spi_link_map.svh"
module spi_conv_dev #(
  parameter int SRC_HALF = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  spi_link_if.dev link,
  input wire logic [15:0] conv_result,
  input wire logic [3:0] chain_id,
  input wire logic [1:0] supply_alarm,
  input wire logic [3:0] input_alarm,
  input wire logic [3:0] range_flags,
  output logic [1:0] host_protocol_select,
  output logic [1:0] read_protocol_select,
  output logic [1:0] second_lane_config,
  output logic forwarded_clock_source_select,
  output logic conv_start
);
  // output word: result, then enabled flags in fixed order, zeros after
  function automatic spi_link_pkg::word_type build_word(input logic [15:0] res, input logic [7:0] ctl,
      input logic [3:0] chn, input logic [1:0] sup, input logic [3:0] inp, input logic [3:0] rng);
    logic [15:0] acc;
    logic [4:0] used;
    acc = 16'h0;
    used = 5'h0;
    if (ctl[`DOUT_CHAIN]) begin
      acc = (acc << `W_CHAIN) | {12'h0, chn};
      used = used + `W_CHAIN;
    end
    if (ctl[`DOUT_SUPPLY]) begin
      acc = (acc << `W_SUPPLY) | {14'h0, sup};
      used = used + `W_SUPPLY;
    end
    if (ctl[`DOUT_INPUT]) begin
      acc = (acc << `W_INPUT) | {12'h0, inp};
      used = used + `W_INPUT;
    end
    if (ctl[`DOUT_RANGE]) begin
      acc = (acc << `W_RANGE) | {12'h0, rng};
      used = used + `W_RANGE;
    end
    if (ctl[`DOUT_PARITY]) begin
      acc = (acc << `W_PARITY) | {14'h0, ^res, ^acc};
      used = used + `W_PARITY;
    end
    acc = acc << (`TAIL_BITS - used);
    return {res, acc};
  endfunction : build_word

  // three-stage synchronisers, bit 0 sclk, bit 1 select, bit 2 sdi
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] filt_r;
  logic [2:0] prev_r;
  wire logic [2:0] agree = ~(sync2_r ^ sync3_r);
  wire logic [2:0] filt_nxt = (agree & sync3_r) | (~agree & filt_r);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= `SYNC_RESET;
      sync2_r <= `SYNC_RESET;
      sync3_r <= `SYNC_RESET;
      filt_r <= `SYNC_RESET;
      prev_r <= `SYNC_RESET;
    end else begin
      sync1_r <= {link.sdi, link.convert_select_pin_n, link.sclk};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end

  // configuration, frame and pin state
  logic [1:0] mode_r;
  logic [7:0] out_ctl_r;
  logic [7:0] dout_ctl_r;
  logic [31:0] rx_r;
  logic [5:0] bit_cnt_r;
  logic [31:0] shreg_r;
  logic din_r;
  logic first_r;
  logic [5:0] src_cnt_r;
  logic [7:0] div_r;
  logic strobe_r;
  logic sdo0_r;
  logic sdo1_r;
  logic start_r;

  // edge and mode decoding
  wire logic active = ~filt_r[1];
  wire logic cs_fall = prev_r[1] & ~filt_r[1];
  wire logic cs_rise = ~prev_r[1] & filt_r[1];
  wire logic sclk_rise = active & ~prev_r[0] & filt_r[0];
  wire logic sclk_fall = active & prev_r[0] & ~filt_r[0];
  wire logic cpol = mode_r[1];
  wire logic cpha = mode_r[0];
  wire logic lead = cpol ? sclk_fall : sclk_rise;
  wire logic trail = cpol ? sclk_rise : sclk_fall;
  wire logic capture = cpha ? trail : lead;
  wire logic launch = cpha ? lead : trail;
  wire logic src = out_ctl_r[`OUT_RD_MSB:`OUT_RD_LSB] != `RD_SPI;
  wire logic dual = out_ctl_r[`OUT_LANE_MSB:`OUT_LANE_LSB] == `DUAL_LANE;
  wire logic int_clk = out_ctl_r[`OUT_CLKSEL];
  wire logic [5:0] limit = dual ? `HALF_WORD_CLKS : `WORD_CLKS;
  wire logic tick = div_r == 8'(SRC_HALF - 1);
  wire logic rise_ev = int_clk ? (tick & ~strobe_r) : lead;
  wire logic fall_ev = int_clk ? (tick & strobe_r) : trail;
  wire logic src_shift = src & active & fall_ev & strobe_r;
  wire logic spi_shift = ~src & launch & ~(cpha & first_r);
  wire logic chain_in = (out_ctl_r == `CTL_RESET) & din_r;
  wire logic [31:0] shift_nxt = dual ? {shreg_r[29:0], 2'h0} : {shreg_r[30:0], chain_in};
  wire logic write_ok = bit_cnt_r >= `MIN_WRITE_BITS;
  wire logic is_write = rx_r[`OP_MSB:`OP_LSB] == `OP_WRITE;
  wire logic [7:0] wr_addr = rx_r[`ADDR_MSB:`ADDR_LSB];
  wire logic [7:0] wr_data = rx_r[`DATA_MSB:`DATA_LSB];
  wire logic take = cs_rise & write_ok & is_write;

  // command capture; only the first 32 bits form a command
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_r <= 32'h0;
      bit_cnt_r <= 6'h0;
      din_r <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_r <= 6'h0;
    end else if (active & capture) begin
      din_r <= filt_r[2];
      if (!write_ok) begin
        rx_r <= {rx_r[30:0], filt_r[2]};
        bit_cnt_r <= bit_cnt_r + 6'h1;
      end
    end
  end

  // register writes land at the end of the frame, so the mode change hits the next frame
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_r <= `MODE_RESET;
      out_ctl_r <= `CTL_RESET;
      dout_ctl_r <= `CTL_RESET;
      start_r <= 1'b0;
    end else begin
      start_r <= cs_rise;
      if (take && wr_addr == `ADDR_IN_CTL) begin
        mode_r <= wr_data[1:0];
      end
      if (take && wr_addr == `ADDR_OUT_CTL) begin
        out_ctl_r <= wr_data;
      end
      if (take && wr_addr == `ADDR_DOUT_CTL) begin
        dout_ctl_r <= wr_data;
      end
    end
  end

  // output shift register; a short frame simply leaves the tail unsent
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shreg_r <= 32'h0;
      first_r <= 1'b0;
    end else if (cs_fall) begin
      shreg_r <= build_word(conv_result, dout_ctl_r, chain_id, supply_alarm, input_alarm, range_flags);
      first_r <= 1'b1;
    end else if (active & (spi_shift | src_shift)) begin
      shreg_r <= shift_nxt;
      first_r <= 1'b0;
    end else if (active & launch) begin
      first_r <= 1'b0;
    end
  end

  // forwarded strobe; internal source divides clk_sys, external follows sclk
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strobe_r <= 1'b0;
      src_cnt_r <= 6'h0;
      div_r <= 8'h0;
    end else if (!src || !active) begin
      strobe_r <= 1'b0;
      src_cnt_r <= 6'h0;
      div_r <= 8'h0;
    end else begin
      div_r <= tick ? 8'h0 : div_r + 8'h1;
      if (rise_ev && src_cnt_r < limit) begin
        strobe_r <= 1'b1;
        src_cnt_r <= src_cnt_r + 6'h1;
      end else if (fall_ev) begin
        strobe_r <= 1'b0;
      end
    end
  end

  // pin registers; shared pin carries the alarm unless dual lane is on
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sdo0_r <= 1'b0;
      sdo1_r <= 1'b0;
    end else begin
      sdo0_r <= shreg_r[`WORD_TOP];
      sdo1_r <= dual ? shreg_r[`WORD_TOP - 1] : |{supply_alarm, input_alarm};
    end
  end

  assign link.serial_out_lane_first = sdo0_r;
  assign link.shared_alarm_output_pin = sdo1_r;
  assign link.strobe_clock_pin = strobe_r;
  assign host_protocol_select = mode_r;
  assign read_protocol_select = out_ctl_r[`OUT_RD_MSB:`OUT_RD_LSB];
  assign second_lane_config = out_ctl_r[`OUT_LANE_MSB:`OUT_LANE_LSB];
  assign forwarded_clock_source_select = out_ctl_r[`OUT_CLKSEL];
  assign conv_start = start_r;
endmodule : spi_conv_dev

// *** pkg/spi_link_map.svh ***
// spi_link_map.svh: offsets, field positions, opcodes and counts of the serial link
// assumes inclusion by bare name from both ends of the link
`ifndef SPI_LINK_MAP_SVH
`define SPI_LINK_MAP_SVH
`define WORD_TOP 31
`define MIN_WRITE_BITS 6'h20
`define WORD_CLKS 6'h20
`define HALF_WORD_CLKS 6'h10
`define OP_MSB 31
`define OP_LSB 24
`define ADDR_MSB 23
`define ADDR_LSB 16
`define DATA_MSB 7
`define DATA_LSB 0
`define OP_WRITE 8'hD0
`define ADDR_IN_CTL 8'h08
`define ADDR_OUT_CTL 8'h0C
`define ADDR_DOUT_CTL 8'h10
`define MODE_RESET 2'h0
`define CTL_RESET 8'h00
`define OUT_RD_MSB 1
`define OUT_RD_LSB 0
`define OUT_LANE_MSB 3
`define OUT_LANE_LSB 2
`define OUT_CLKSEL 6
`define DUAL_LANE 2'h3
`define RD_SPI 2'h0
`define DOUT_CHAIN 0
`define DOUT_SUPPLY 1
`define DOUT_INPUT 2
`define DOUT_RANGE 3
`define DOUT_PARITY 4
`define W_CHAIN 5'h4
`define W_SUPPLY 5'h2
`define W_INPUT 5'h4
`define W_RANGE 5'h4
`define W_PARITY 5'h2
`define TAIL_BITS 5'h10
`define HR_GO 2'h0
`define HR_TX 2'h1
`define HR_RX 2'h2
`define HR_STAT 2'h3
`define GO_BITS_MSB 6
`define GO_BITS_LSB 0
`define GO_MODE_MSB 9
`define GO_MODE_LSB 8
`define GO_DUAL 10
`define GO_SRC 11
`define SYNC_RESET 3'h2
`endif

// *** pkg/spi_link_pkg.sv ***
// spi_link_pkg: types shared by both ends of the serial link
// assumes spi_link_map.svh carries every number
package spi_link_pkg;
  typedef logic [31:0] word_type;
  typedef enum {H_IDLE, H_LEAD, H_EDGE, H_TAIL, H_GAP} host_state_type;
endpackage : spi_link_pkg

// *** pkg/spi_link_if.sv ***
// spi_link_if: the pins between host controller and converter
// assumes every pin is one-way; both ends run on their own system clock
`timescale 1ns/100ps
interface spi_link_if;
  logic sclk;
  logic convert_select_pin_n;
  logic sdi;
  logic serial_out_lane_first;
  logic shared_alarm_output_pin;
  logic strobe_clock_pin;
  modport dev (input sclk, input convert_select_pin_n, input sdi,
               output serial_out_lane_first, output shared_alarm_output_pin, output strobe_clock_pin);
  modport host (output sclk, output convert_select_pin_n, output sdi,
                input serial_out_lane_first, input shared_alarm_output_pin, input strobe_clock_pin);
endinterface : spi_link_if

// *** core/spi_host_ctl.sv ***
// spi_host_ctl: host end, makes sclk by dividing clk_sys and runs one frame per start
// assumes the caller gives the protocol the converter currently expects
`timescale 1ns/100ps
`include "spi_link_map.svh"
module spi_host_ctl #(
  parameter int HALF = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  spi_link_if.host link,
  input wire logic [1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  spi_link_pkg::host_state_type state_r;
  logic [7:0] tmr_r;
  logic [7:0] edge_cnt_r;
  logic [6:0] clks_r;
  logic [6:0] cap_cnt_r;
  logic [1:0] mode_r;
  logic dual_r;
  logic src_r;
  logic sclk_r;
  logic cs_n_r;
  logic sdi_r;
  logic first_r;
  logic [31:0] tx_r;
  logic [31:0] rx_r;
  logic done_r;
  logic [31:0] rx_word_r;
  logic wait_r;
  logic [31:0] readdata_r;
  logic [31:0] tx_hold_r;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] filt_r;
  logic [2:0] prev_r;

  // device pins: bit 0 lane one, bit 1 lane two, bit 2 strobe
  wire logic [2:0] agree = ~(sync2_r ^ sync3_r);
  wire logic [2:0] filt_nxt = (agree & sync3_r) | (~agree & filt_r);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
      filt_r <= 3'h0;
      prev_r <= 3'h0;
    end else begin
      sync1_r <= {link.strobe_clock_pin, link.shared_alarm_output_pin, link.serial_out_lane_first};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end

  // register port: one wait state per access, so readdata is a flop standing at the accepting edge
  wire logic accept = (read | write) & ~wait_r;
  wire logic busy = state_r != spi_link_pkg::H_IDLE;
  wire logic start = write & accept & (address == `HR_GO) & ~busy;
  wire logic [31:0] tx_word = tx_hold_r;
  wire logic [6:0] frame_bits = writedata[`GO_BITS_MSB:`GO_BITS_LSB];
  wire logic [1:0] mode = writedata[`GO_MODE_MSB:`GO_MODE_LSB];
  wire logic dual = writedata[`GO_DUAL];
  wire logic src = writedata[`GO_SRC];
  wire logic [31:0] rd_mux = (address == `HR_RX) ? rx_word_r :
                             (address == `HR_STAT) ? {30'h0, done_r, busy} : tx_hold_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_r <= 1'b1;
      readdata_r <= 32'h0;
      tx_hold_r <= 32'h0;
    end else begin
      wait_r <= ~((read | write) & wait_r);
      readdata_r <= rd_mux;
      if (write && accept && address == `HR_TX) begin
        tx_hold_r <= writedata;
      end
    end
  end

  // timing and edge decoding
  wire logic tmr_done = tmr_r >= 8'(HALF - 1);
  wire logic is_lead = ~edge_cnt_r[0];
  wire logic launch = mode_r[0] ? is_lead : ~is_lead;
  wire logic last_edge = edge_cnt_r == ({clks_r, 1'b0} - 8'h1);
  wire logic tick = (state_r == spi_link_pkg::H_EDGE) & tmr_done;
  wire logic strobe_rise = ~prev_r[2] & filt_r[2];
  wire logic cap = src_r ? (strobe_rise & ~cs_n_r & cap_cnt_r < clks_r) : (tick & ~launch);
  wire logic [31:0] rx_nxt = dual_r ? {rx_r[29:0], filt_r[0], filt_r[1]} : {rx_r[30:0], filt_r[0]};
  wire logic [6:0] clks_nxt = dual ? {1'b0, frame_bits[6:1]} : frame_bits;
  wire logic caught_all = ~src_r | (cap_cnt_r >= clks_r);

  // frame sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= spi_link_pkg::H_IDLE;
      tmr_r <= 8'h0;
      edge_cnt_r <= 8'h0;
      clks_r <= 7'h0;
      mode_r <= `MODE_RESET;
      dual_r <= 1'b0;
      src_r <= 1'b0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      done_r <= 1'b0;
      rx_word_r <= 32'h0;
    end else begin
      tmr_r <= tmr_done ? tmr_r : tmr_r + 8'h1;
      case (state_r)
        spi_link_pkg::H_IDLE: begin
          sclk_r <= mode_r[1];
          if (start) begin
            mode_r <= mode;
            done_r <= 1'b0;
            dual_r <= dual;
            src_r <= src;
            clks_r <= clks_nxt;
            sclk_r <= mode[1];
            cs_n_r <= 1'b0;
            tmr_r <= 8'h0;
            edge_cnt_r <= 8'h0;
            state_r <= (clks_nxt == 7'h0) ? spi_link_pkg::H_TAIL : spi_link_pkg::H_LEAD;
          end
        end
        spi_link_pkg::H_LEAD: begin
          if (tmr_done) begin
            tmr_r <= 8'h0;
            state_r <= spi_link_pkg::H_EDGE;
          end
        end
        spi_link_pkg::H_EDGE: begin
          if (tmr_done) begin
            tmr_r <= 8'h0;
            sclk_r <= ~sclk_r;
            edge_cnt_r <= edge_cnt_r + 8'h1;
            if (last_edge) begin
              state_r <= spi_link_pkg::H_TAIL;
            end
          end
        end
        spi_link_pkg::H_TAIL: begin
          if (tmr_done && caught_all) begin
            cs_n_r <= 1'b1;
            tmr_r <= 8'h0;
            state_r <= spi_link_pkg::H_GAP;
          end
        end
        spi_link_pkg::H_GAP: begin
          if (tmr_done) begin
            done_r <= 1'b1;
            rx_word_r <= rx_r;
            state_r <= spi_link_pkg::H_IDLE;
          end
        end
        default: begin
          state_r <= spi_link_pkg::H_IDLE;
        end
      endcase
    end
  end

  // data path; a phase-one mode puts the msb out on the first leading edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_r <= 32'h0;
      sdi_r <= 1'b0;
      first_r <= 1'b0;
      rx_r <= 32'h0;
      cap_cnt_r <= 7'h0;
    end else if (state_r == spi_link_pkg::H_IDLE && start) begin
      tx_r <= tx_word;
      sdi_r <= mode[0] ? 1'b0 : tx_word[`WORD_TOP];
      first_r <= mode[0];
      rx_r <= 32'h0;
      cap_cnt_r <= 7'h0;
    end else begin
      if (tick && launch && first_r) begin
        sdi_r <= tx_r[`WORD_TOP];
        first_r <= 1'b0;
      end else if (tick && launch) begin
        tx_r <= {tx_r[30:0], 1'b0};
        sdi_r <= tx_r[`WORD_TOP - 1];
      end
      if (cap) begin
        rx_r <= rx_nxt;
        cap_cnt_r <= cap_cnt_r + 7'h1;
      end
    end
  end

  assign link.sclk = sclk_r;
  assign link.convert_select_pin_n = cs_n_r;
  assign link.sdi = sdi_r;
  assign readdata = readdata_r;
  assign waitrequest = wait_r;
endmodule : spi_host_ctl

// *** verification/spi_link_asserts.sv ***
// spi_link_asserts: framing and timing checks on the link between both ends
// assumes interface signals and the converter's config outputs are wired by name
`timescale 1ns/100ps
`include "spi_link_map.svh"
module spi_link_asserts (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic convert_select_pin_n,
  input wire logic strobe_clock_pin,
  input wire logic [1:0] host_protocol_select,
  input wire logic [1:0] read_protocol_select,
  input wire logic [1:0] second_lane_config,
  input wire logic conv_start
);
  logic cs_d_r;
  logic sclk_d_r;
  logic strobe_d_r;
  logic [7:0] sclk_edges_r;
  logic [7:0] strobe_rises_r;
  // skip the select edge itself, where the host may move sclk to a new idle level
  wire in_frame = !convert_select_pin_n && !cs_d_r;
  wire [7:0] rise_cap = (second_lane_config == `DUAL_LANE) ? 8'h10 : 8'h20;

  // per-frame edge counts, cleared while select is high
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cs_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      strobe_d_r <= 1'b0;
      sclk_edges_r <= 8'h00;
      strobe_rises_r <= 8'h00;
    end else begin
      cs_d_r <= convert_select_pin_n;
      sclk_d_r <= sclk;
      strobe_d_r <= strobe_clock_pin;
      sclk_edges_r <= !in_frame ? 8'h00 : sclk_edges_r + 8'(sclk != sclk_d_r);
      strobe_rises_r <= !in_frame ? 8'h00 : strobe_rises_r + 8'(strobe_clock_pin && !strobe_d_r);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  reset_mode_a: assert property ($rose(rstn) |-> host_protocol_select == `MODE_RESET)
    else $error("protocol not default after reset");
  idle_level_a: assert property ($fell(convert_select_pin_n) |-> sclk == host_protocol_select[1])
    else $error("sclk idle level wrong at frame start");
  end_level_a: assert property ($rose(convert_select_pin_n) |-> sclk == host_protocol_select[1])
    else $error("sclk idle level wrong at frame end");
  strobe_low_a: assert property (read_protocol_select == `RD_SPI |-> !strobe_clock_pin)
    else $error("strobe moved in spi read mode");
  strobe_idle_a: assert property (convert_select_pin_n [*8] |-> !strobe_clock_pin)
    else $error("strobe high outside frame");
  conv_pulse_a: assert property ($rose(convert_select_pin_n) |-> ##[2:8] conv_start)
    else $error("no conversion start after frame");
  conv_single_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  cfg_at_rise_a: assert property ($changed(host_protocol_select) || $changed(second_lane_config)
    |-> convert_select_pin_n && $past(convert_select_pin_n))
    else $error("config changed inside a frame");
  whole_cycles_a: assert property ($rose(convert_select_pin_n) |-> !sclk_edges_r[0])
    else $error("frame ended on half a clock");
  strobe_count_a: assert property ($rose(convert_select_pin_n) |-> strobe_rises_r <= rise_cap)
    else $error("too many forwarded clock rises");

  mode3_c: cover property ($fell(convert_select_pin_n) && host_protocol_select == 2'h3);
  dual_c: cover property ($fell(convert_select_pin_n) && second_lane_config == `DUAL_LANE);
  src_c: cover property (read_protocol_select != `RD_SPI && $rose(strobe_clock_pin));
endmodule : spi_link_asserts

// *** verification/testbench.sv ***
// testbench: host and converter joined by the link, checked against a word model
// assumes host HALF of 16 clocks and SRC_HALF of 8; all config goes over the link
`timescale 1ns/100ps
`include "spi_link_map.svh"
module testbench;
  logic clk_sys, rstn, read, write, waitrequest, fcs, conv_start;
  logic [31:0] tx_word, writedata, readdata, rx, w;
  logic [1:0] address, hps, rps, slc, sup, md;
  logic [15:0] res;
  logic [3:0] cid, inp, rng;
  logic [4:0] en;
  integer seed = 32'h5A49;
  int err_count, compares;

  spi_link_if link_bus ();
  spi_conv_dev #(.SRC_HALF(8)) spi_conv_dev_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link_bus),
    .conv_result(res), .chain_id(cid), .supply_alarm(sup), .input_alarm(inp), .range_flags(rng),
    .host_protocol_select(hps), .read_protocol_select(rps), .second_lane_config(slc),
    .forwarded_clock_source_select(fcs), .conv_start(conv_start));
  spi_host_ctl #(.HALF(16)) spi_host_ctl_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link_bus),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest));
  spi_link_asserts spi_link_asserts_inst (.clk_sys(clk_sys), .rstn(rstn), .sclk(link_bus.sclk),
    .convert_select_pin_n(link_bus.convert_select_pin_n), .strobe_clock_pin(link_bus.strobe_clock_pin),
    .host_protocol_select(hps), .read_protocol_select(rps), .second_lane_config(slc),
    .conv_start(conv_start));

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // expected word: result, enabled flags in fixed order, parity, zeros
  function automatic logic [31:0] model();
    logic [31:0] m;
    logic [13:0] f;
    logic fp;
    int p;
    m = {res, 16'h0000};
    f = {cid, sup, inp, rng};
    p = 15;
    fp = 1'b0;
    for (int k = 0; k < 14; k++) begin
      if (en[k < 4 ? 0 : k < 6 ? 1 : k < 10 ? 2 : 3]) begin
        m[p] = f[13 - k];
        fp ^= f[13 - k];
        p--;
      end
    end
    if (en[4]) begin
      m[p] = ^res;
      m[p - 1] = fp;
    end
    return m;
  endfunction : model

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // one register access; the request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr_en, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    address <= a;
    read <= ~wr_en;
    write <= wr_en;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 64) begin
      err_count++;
      $display("MISMATCH waitrequest expected 0 seen 1");
    end
  endtask : bus

  // one frame: load the word, start it, poll until done and idle, then fetch the received bits
  task automatic run(input logic [31:0] tx, input logic [6:0] nb, input logic dl, input logic sr);
    logic [31:0] q;
    int n;
    tx_word = tx;
    bus(1'b1, `HR_TX, tx, q);
    bus(1'b1, `HR_GO, {20'h0_0000, sr, dl, md, 1'b0, nb}, q);
    n = 0;
    do begin
      bus(1'b0, `HR_STAT, 32'h0000_0000, q);
      if (n == 0) chk("busy", {30'h0, q[1:0]}, 32'h0000_0001);
      n++;
    end while (q[1:0] !== 2'h2 && n < 2000);
    if (n >= 2000) begin
      err_count++;
      $display("MISMATCH done expected 1 seen 0");
    end
    bus(1'b0, `HR_RX, 32'h0000_0000, rx);
  endtask : run

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sr);
    run({`OP_WRITE, a, 8'h00, d}, 7'h20, 1'b0, sr);
  endtask : wr

  // fresh random inputs, then a read checked against the model, right-aligned
  task automatic rd(input string nm, input logic [6:0] nb, input logic dl, input logic sr);
    @(posedge clk_sys);
    res <= 16'($random(seed));
    cid <= 4'($random(seed));
    sup <= 2'($random(seed));
    inp <= 4'($random(seed));
    rng <= 4'($random(seed));
    run(32'h0000_0000, nb, dl, sr);
    w = model();
    chk(nm, rx, w >> (7'h20 - nb));
    $display("done %s", nm);
  endtask : rd

  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 2'h0;
    writedata = 32'h0000_0000;
    tx_word = 32'h0000_0000;
    {res, cid, sup, inp, rng} = 30'h0000_0000;
    en = 5'h00;
    md = 2'h0;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("reset_cfg", {24'h00_0000, hps, rps, slc, 1'b0, fcs}, 32'h0000_0000);
    rd("plain_word", 7'h20, 1'b0, 1'b0);
    wr(`ADDR_DOUT_CTL, 8'h1A, 1'b0);
    en = 5'h1A;
    rd("flag_word", 7'h20, 1'b0, 1'b0);
    rd("short_read", 7'h10, 1'b0, 1'b0);
    // a write one clock short must be dropped
    run({`OP_WRITE, `ADDR_IN_CTL, 16'h0003}, 7'h1F, 1'b0, 1'b0);
    chk("short_write", {30'h0, hps}, 32'h0000_0000);
    for (int m = 1; m < 5; m++) begin
      wr(`ADDR_IN_CTL, 8'(m % 4), 1'b0);
      md = 2'(m % 4);
      chk("mode_sel", {30'h0, hps}, {30'h0, md});
      en = 5'($random(seed));
      wr(`ADDR_DOUT_CTL, {3'h0, en}, 1'b0);
      rd("mode_read", 7'h20, 1'b0, 1'b0);
    end
    // long frame with output control zero passes sdi bits onward
    run({1'b0, 31'($random(seed))}, 7'h28, 1'b0, 1'b0);
    w = model();
    chk("chain", rx, {w[23:0], tx_word[31:24]});
    chk("alarm_pin", {31'h0, link_bus.shared_alarm_output_pin}, {31'h0, (|sup) || (|inp)});
    wr(`ADDR_OUT_CTL, 8'h0C, 1'b0);
    chk("lane_cfg", {30'h0, slc}, {30'h0, `DUAL_LANE});
    rd("dual_read", 7'h20, 1'b1, 1'b0);
    rd("dual_short", 7'h10, 1'b1, 1'b0);
    wr(`ADDR_OUT_CTL, 8'h41, 1'b0);
    chk("src_int_cfg", {30'h0, rps, fcs}, 32'h0000_0003);
    rd("src_int", 7'h20, 1'b0, 1'b1);
    wr(`ADDR_OUT_CTL, 8'h01, 1'b1);
    chk("src_ext_cfg", {31'h0, fcs}, 32'h0000_0000);
    rd("src_ext", 7'h20, 1'b0, 1'b1);
    wr(`ADDR_OUT_CTL, 8'h4D, 1'b1);
    rd("src_dual", 7'h20, 1'b1, 1'b1);
    // second reset between frames must restore the default protocol and clear every control
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("reset_again", {24'h00_0000, hps, rps, slc, 1'b0, fcs}, 32'h0000_0000);
    en = 5'h00;
    md = 2'h0;
    rd("after_reset", 7'h20, 1'b0, 1'b0);
    test_done();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule : testbench
